// ===== logic/esi_pkg.sv
package esi_pkg;

  // ==========================================================
  // Register map (byte addresses, one word each)
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_ACTION = 4'h8;
  localparam logic [3:0] ADDR_MACRO = 4'hc;

  // ==========================================================
  // Config bit positions
  localparam int CFG_ESTOP_INPUT_DISABLE = 0;
  localparam int CFG_ESTOP_OUTPUT_SCOPE = 1;
  localparam int CFG_ESTOP_MACRO_ENABLE = 2;
  localparam int CFG_DRIVE_ALARM_CHECK_DISABLE = 3;
  localparam int CFG_DRIVE_ALARM_LEVEL_Y = 4;
  localparam int CFG_DRIVE_ALARM_LEVEL_X = 5;
  localparam int CFG_DRIVE_ALARM_LEVEL_Z = 6;
  localparam int CFG_RESET_SPINDLE_HOLD = 7;
  localparam int CFG_RESET_MACRO_ENABLE = 8;
  localparam int CFG_WIDTH = 9;
  localparam logic [8:0] CFG_RESET = 9'h000;

  // Action register bits (write one to request)
  localparam int ACT_RESET_KEY = 0;
  localparam int ACT_PANEL_KEY = 1;
  localparam int ACT_CYCLE_START = 2;
  localparam int ACT_CLEAR_ALARM = 3;

  // Macro register bits
  localparam int MAC_ESTOP_STORED = 0;
  localparam int MAC_RESET_STORED = 1;

  // Modal code values loaded by the reset key action
  localparam logic [1:0] MOTION_RAPID = 2'h0;
  localparam logic [1:0] SPEED_CONSTANT = 2'h1;
  localparam logic [1:0] FEED_PER_MINUTE = 2'h1;

  localparam logic [7:0] AUX_OFF = 8'h00;

  // ==========================================================
  typedef enum logic [2:0] {
    MODE_STARTUP = 3'b000,
    MODE_EDIT = 3'b001,
    MODE_MANUAL = 3'b010,
    MODE_AUTO = 3'b011,
    MODE_OTHER = 3'b100,
    MODE_ESTOP = 3'b101
  } esi_mode_t;

  typedef enum logic [1:0] {
    MAC_IDLE = 2'b00,
    MAC_WAIT_STOP = 2'b01,
    MAC_RUN = 2'b10
  } esi_mac_state_t;

  // Auxiliary outputs
  typedef struct packed {
    logic tailstock;
    logic chuck;
    logic other2;
    logic other1;
    logic other0;
    logic lubricant;
    logic coolant;
    logic spindle;
  } esi_aux_t;

  typedef struct packed {
    logic [1:0] motion;
    logic [1:0] speed;
    logic [1:0] feed;
  } esi_modal_t;

endpackage : esi_pkg

// ===== logic/esi_sync.sv
`timescale 1ns/100ps
module esi_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = i_d;
    next_q = meta;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= '0;
      o_q <= '0;
    end else begin
      meta <= next_meta;
      o_q <= next_q;
    end
  end
endmodule : esi_sync

// ===== logic/esi_interlock.sv
`timescale 1ns/100ps
module esi_interlock (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_external_stop_input_n,
  input wire logic [2:0] i_drive_alarm,
  input wire logic [2:0] i_mode_select,
  input wire logic i_mode_select_valid,
  input wire esi_pkg::esi_aux_t i_aux_request,
  input wire logic i_macro_done,
  output esi_pkg::esi_aux_t o_aux,
  output logic o_feed_stop,
  output logic o_feed_decel,
  output logic o_program_run,
  output logic o_estop_macro_run,
  output logic o_reset_macro_run,
  output esi_pkg::esi_mode_t o_mode,
  output esi_pkg::esi_modal_t o_modal,
  output logic o_estop_alarm,
  output logic [2:0] o_drive_alarm_flag
);
  // ==========================================================
  // Pin synchronisers
  logic [3:0] pins_sync;
  esi_sync #(.W(4)) esi_sync_i (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d({~i_external_stop_input_n, ~i_drive_alarm}),
    .o_q(pins_sync)
  );

  // ==========================================================
  // Registers and state
  logic [8:0] cfg;
  logic [1:0] macro_stored;
  logic waitreq;
  logic [3:0] act;
  esi_pkg::esi_mode_t mode;
  esi_pkg::esi_mode_t saved_mode;
  esi_pkg::esi_mac_state_t mac;
  logic mac_is_reset, estop_run, reset_run;
  logic running;
  logic [2:0] dflag;
  logic estop_alarm;
  esi_pkg::esi_aux_t aux;
  esi_pkg::esi_modal_t modal;
  logic feed_stop;
  logic feed_decel;
  logic [31:0] rdata;

  logic [8:0] next_cfg;
  logic [1:0] next_macro_stored;
  logic next_waitreq;
  logic [3:0] next_act;
  esi_pkg::esi_mode_t next_mode;
  esi_pkg::esi_mode_t next_saved_mode;
  esi_pkg::esi_mac_state_t next_mac;
  logic next_mac_is_reset, next_estop_run, next_reset_run;
  logic next_running;
  logic [2:0] next_dflag;
  logic next_estop_alarm;
  esi_pkg::esi_aux_t next_aux;
  esi_pkg::esi_modal_t next_modal;
  logic next_feed_stop;
  logic next_feed_decel;
  logic [31:0] next_rdata;

  logic estop_active;
  logic [2:0] levels;
  logic [2:0] drive_hit;
  logic drive_any;
  logic run_mode;

  function automatic esi_pkg::esi_aux_t stop_mask(input esi_pkg::esi_aux_t a,
                                                  input logic scope_all);
    esi_pkg::esi_aux_t r;
    r = a;
    if (scope_all) begin
      r = esi_pkg::AUX_OFF;
    end else begin
      r.spindle = 1'b0;
      r.coolant = 1'b0;
      r.lubricant = 1'b0;
    end
    return r;
  endfunction : stop_mask

  // ==========================================================
  // Alarm detection
  always_comb begin
    estop_active = pins_sync[3] & ~cfg[esi_pkg::CFG_ESTOP_INPUT_DISABLE];
    levels = {cfg[esi_pkg::CFG_DRIVE_ALARM_LEVEL_Z], cfg[esi_pkg::CFG_DRIVE_ALARM_LEVEL_X],
              cfg[esi_pkg::CFG_DRIVE_ALARM_LEVEL_Y]};
    drive_hit = (pins_sync[2:0] ^ levels) &
                {3{~cfg[esi_pkg::CFG_DRIVE_ALARM_CHECK_DISABLE]}};
    drive_any = |drive_hit;
    run_mode = (mode == esi_pkg::MODE_MANUAL) || (mode == esi_pkg::MODE_AUTO);
  end

  // ==========================================================
  // Bus slave: one wait cycle, then answer
  always_comb begin
    next_waitreq = ~((i_avs_read | i_avs_write) & waitreq);
    next_cfg = cfg;
    next_macro_stored = macro_stored;
    next_act = '0;
    next_rdata = rdata;
    if (!waitreq && i_avs_write) begin
      if (i_avs_address == esi_pkg::ADDR_CONFIG) begin
        next_cfg = i_avs_writedata[8:0];
      end else if (i_avs_address == esi_pkg::ADDR_ACTION) begin
        next_act = i_avs_writedata[3:0];
      end else if (i_avs_address == esi_pkg::ADDR_MACRO) begin
        next_macro_stored = i_avs_writedata[1:0];
      end
    end
    if (!next_waitreq && i_avs_read) begin
      if (i_avs_address == esi_pkg::ADDR_CONFIG) begin
        next_rdata = {23'h000000, cfg};
      end else if (i_avs_address == esi_pkg::ADDR_STATUS) begin
        next_rdata = {20'h00000, mac, running, mode, feed_stop, feed_decel,
                      estop_alarm, dflag};
      end else if (i_avs_address == esi_pkg::ADDR_MACRO) begin
        next_rdata = {30'h00000000, macro_stored};
      end else begin
        next_rdata = 32'h00000000;
      end
    end
  end

  // ==========================================================
  // Mode, alarms, outputs
  always_comb begin
    next_mode = mode;
    next_saved_mode = saved_mode;
    next_mac = mac;
    next_mac_is_reset = mac_is_reset;
    next_running = running;
    next_dflag = dflag | drive_hit;
    next_estop_alarm = estop_alarm;
    next_aux = i_aux_request;
    next_modal = modal;
    next_feed_stop = 1'b0;
    next_feed_decel = 1'b0;
    if (act[esi_pkg::ACT_CLEAR_ALARM] && !drive_any) begin
      next_dflag = drive_hit;
    end
    if (mode == esi_pkg::MODE_STARTUP) begin
      if (act[esi_pkg::ACT_PANEL_KEY]) begin
        next_mode = esi_pkg::MODE_EDIT;
      end
    end else if (i_mode_select_valid && mode != esi_pkg::MODE_ESTOP &&
                 i_mode_select >= 3'h1 && i_mode_select <= 3'h4) begin
      next_mode = esi_pkg::esi_mode_t'(i_mode_select);
      next_running = 1'b0;
    end
    if (act[esi_pkg::ACT_CYCLE_START] && mode == esi_pkg::MODE_AUTO &&
        !drive_any && dflag == 3'h0 && !estop_alarm) begin
      next_running = 1'b1;
    end
    if (drive_any) begin
      next_running = 1'b0;
      next_feed_stop = 1'b1;
    end
    // Emergency stop entry
    if (estop_active && mode != esi_pkg::MODE_ESTOP && mode != esi_pkg::MODE_STARTUP) begin
      next_saved_mode = mode;
      next_mode = esi_pkg::MODE_ESTOP;
      next_estop_alarm = 1'b1;
      next_running = 1'b0;
      if (cfg[esi_pkg::CFG_ESTOP_MACRO_ENABLE] && run_mode &&
          macro_stored[esi_pkg::MAC_ESTOP_STORED]) begin
        next_mac = esi_pkg::MAC_WAIT_STOP;
        next_mac_is_reset = 1'b0;
      end else begin
        next_mac = esi_pkg::MAC_IDLE;
      end
    end else if (act[esi_pkg::ACT_RESET_KEY]) begin
      next_feed_decel = 1'b1;
      next_running = 1'b0;
      next_modal.motion = esi_pkg::MOTION_RAPID;
      next_modal.speed = esi_pkg::SPEED_CONSTANT;
      next_modal.feed = esi_pkg::FEED_PER_MINUTE;
      next_mac = esi_pkg::MAC_IDLE;
      if (mode == esi_pkg::MODE_ESTOP && !estop_active) begin
        next_mode = saved_mode;
        next_estop_alarm = 1'b0;
      end else if (run_mode && cfg[esi_pkg::CFG_RESET_MACRO_ENABLE] &&
                   macro_stored[esi_pkg::MAC_RESET_STORED]) begin
        next_mac = esi_pkg::MAC_WAIT_STOP;
        next_mac_is_reset = 1'b1;
      end
    end else begin
      case (mac)
        esi_pkg::MAC_WAIT_STOP: begin
          next_mac = esi_pkg::MAC_RUN;
        end
        esi_pkg::MAC_RUN: begin
          if (i_macro_done) begin
            next_mac = esi_pkg::MAC_IDLE;
          end
          if (mac_is_reset && (drive_any || estop_active)) begin
            next_mac = esi_pkg::MAC_IDLE;
          end
        end
        default: begin
          next_mac = esi_pkg::MAC_IDLE;
        end
      endcase
    end
    if (next_mode == esi_pkg::MODE_ESTOP) begin
      next_feed_stop = 1'b1;
      next_aux = stop_mask(i_aux_request, cfg[esi_pkg::CFG_ESTOP_OUTPUT_SCOPE]);
    end else if (act[esi_pkg::ACT_RESET_KEY] && !cfg[esi_pkg::CFG_RESET_SPINDLE_HOLD]) begin
      next_aux.spindle = 1'b0;
      next_aux.coolant = 1'b0;
    end else if (act[esi_pkg::ACT_RESET_KEY]) begin
      next_aux = aux;
    end
    next_estop_run = (next_mac == esi_pkg::MAC_RUN) & ~next_mac_is_reset;
    next_reset_run = (next_mac == esi_pkg::MAC_RUN) & next_mac_is_reset;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg <= esi_pkg::CFG_RESET;
      macro_stored <= 2'h0;
      waitreq <= 1'b1;
      act <= 4'h0;
      rdata <= 32'h00000000;
      mode <= esi_pkg::MODE_STARTUP;
      saved_mode <= esi_pkg::MODE_EDIT;
      mac <= esi_pkg::MAC_IDLE;
      mac_is_reset <= 1'b0;
      estop_run <= 1'b0;
      reset_run <= 1'b0;
      running <= 1'b0;
      dflag <= 3'h0;
      estop_alarm <= 1'b0;
      aux <= esi_pkg::AUX_OFF;
      modal <= '0;
      feed_stop <= 1'b0;
      feed_decel <= 1'b0;
    end else begin
      cfg <= next_cfg;
      macro_stored <= next_macro_stored;
      waitreq <= next_waitreq;
      act <= next_act;
      rdata <= next_rdata;
      mode <= next_mode;
      saved_mode <= next_saved_mode;
      mac <= next_mac;
      mac_is_reset <= next_mac_is_reset;
      estop_run <= next_estop_run;
      reset_run <= next_reset_run;
      running <= next_running;
      dflag <= next_dflag;
      estop_alarm <= next_estop_alarm;
      aux <= next_aux;
      modal <= next_modal;
      feed_stop <= next_feed_stop;
      feed_decel <= next_feed_decel;
    end
  end

  always_comb begin
    o_avs_waitrequest = waitreq;
    o_avs_readdata = rdata;
    o_aux = aux;
    o_feed_stop = feed_stop;
    o_feed_decel = feed_decel;
    o_program_run = running;
    o_estop_macro_run = estop_run;
    o_reset_macro_run = reset_run;
    o_mode = mode;
    o_modal = modal;
    o_estop_alarm = estop_alarm;
    o_drive_alarm_flag = dflag;
  end

  // ==========================================================
  // Checks
  a_estop_disable_ignored: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    cfg[esi_pkg::CFG_ESTOP_INPUT_DISABLE] && !estop_alarm |=> !estop_alarm)
    else $error("stop input honoured while disabled");
  a_scope_zero_aux: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    mode == esi_pkg::MODE_ESTOP && !cfg[esi_pkg::CFG_ESTOP_OUTPUT_SCOPE] |->
    !aux.spindle && !aux.coolant && !aux.lubricant)
    else $error("spindle group on during stop");
  a_scope_one_aux: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    mode == esi_pkg::MODE_ESTOP && $past(cfg[esi_pkg::CFG_ESTOP_OUTPUT_SCOPE]) &&
    $past(mode) == esi_pkg::MODE_ESTOP |-> aux == esi_pkg::AUX_OFF)
    else $error("aux output on during full stop");
  a_drive_stops_run: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    drive_any |=> !running && feed_stop && (dflag & $past(drive_hit)) == $past(drive_hit))
    else $error("drive alarm did not halt");
  a_auto_start_block: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !running && dflag != 3'h0 |=> !running)
    else $error("program started with drive alarm");
  a_check_disable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    cfg[esi_pkg::CFG_DRIVE_ALARM_CHECK_DISABLE] |-> drive_hit == 3'h0)
    else $error("drive alarm seen while check off");
  a_reset_modal: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    act[esi_pkg::ACT_RESET_KEY] |=> feed_decel && !running &&
    modal.motion == esi_pkg::MOTION_RAPID)
    else $error("reset action incomplete");
  a_startup_edit: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    mode == esi_pkg::MODE_STARTUP && act[esi_pkg::ACT_PANEL_KEY] |=>
    mode == esi_pkg::MODE_EDIT)
    else $error("panel key did not enter edit");
endmodule : esi_interlock

// ===== dv/esi_plant.sv
`timescale 1ns/100ps
// ==========================================================
// Stop switch, drive units and custom macro executor
module esi_plant (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_press,
  input wire logic [2:0] i_pins,
  input wire logic [3:0] i_macro_delay,
  input wire logic i_estop_macro_run,
  input wire logic i_reset_macro_run,
  output logic o_stop_n,
  output logic [2:0] o_drive_alarm,
  output logic o_macro_done
);
  logic [3:0] count;
  logic [3:0] next_count;
  // Closed contact opens when pressed, so the line falls
  assign o_stop_n = ~i_press;
  assign o_drive_alarm = i_pins;
  always_comb begin
    next_count = 4'h0;
    if (i_estop_macro_run || i_reset_macro_run) begin
      next_count = count + 4'h1;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= 4'h0;
    end else begin
      count <= next_count;
    end
  end
  // Zero delay: the macro never reports completion
  assign o_macro_done = (i_macro_delay != 4'h0) && (count == i_macro_delay);
endmodule : esi_plant

// ===== dv/esi_interlock_tb.sv
`timescale 1ns/100ps
module esi_interlock_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wtreq;
  logic press = 1'b0;
  logic [2:0] pins = 3'h7;
  logic [2:0] mode_sel = 3'h0;
  logic mode_valid = 1'b0;
  esi_pkg::esi_aux_t aux_req = 8'h00;
  logic [3:0] macro_delay = 4'h0;
  logic stop_n, macro_done, feed_stop, feed_decel, program_run, estop_mac, reset_mac;
  logic estop_alarm;
  logic [2:0] drive_pins, dflag;
  esi_pkg::esi_aux_t aux;
  esi_pkg::esi_mode_t mode;
  esi_pkg::esi_modal_t modal;
  logic [31:0] q;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;

  always #10 clk = ~clk;

  esi_interlock esi_interlock_i (.i_clk(clk), .i_rst_n(rst_n), .i_avs_address(address),
    .i_avs_read(read), .i_avs_write(write), .i_avs_writedata(wdata),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wtreq), .i_external_stop_input_n(stop_n),
    .i_drive_alarm(drive_pins), .i_mode_select(mode_sel), .i_mode_select_valid(mode_valid),
    .i_aux_request(aux_req), .i_macro_done(macro_done), .o_aux(aux), .o_feed_stop(feed_stop),
    .o_feed_decel(feed_decel), .o_program_run(program_run), .o_estop_macro_run(estop_mac),
    .o_reset_macro_run(reset_mac), .o_mode(mode), .o_modal(modal),
    .o_estop_alarm(estop_alarm), .o_drive_alarm_flag(dflag));

  esi_plant esi_plant_i (.i_clk(clk), .i_rst_n(rst_n), .i_press(press), .i_pins(pins),
    .i_macro_delay(macro_delay), .i_estop_macro_run(estop_mac), .i_reset_macro_run(reset_mac),
    .o_stop_n(stop_n), .o_drive_alarm(drive_pins), .o_macro_done(macro_done));

  // ==========================================================
  // Verdict and watchdog
  task automatic conclude();
    if (miscompares == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end

  // ==========================================================
  // Compare and bus tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    wdata <= d;
    write <= wr;
    read <= ~wr;
    // Waitrequest and read data are taken at the same rising edge
    @(posedge clk);
    while (wtreq !== 1'b0 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n >= 50) begin
      miscompares++;
      $display("BAD waitrequest expected 0 seen %b", wtreq);
    end
    q = rdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus

  task automatic act(input int b);
    bus(1'b1, esi_pkg::ADDR_ACTION, 32'h1 << b);
  endtask : act

  task automatic cfg(input logic [31:0] v);
    bus(1'b1, esi_pkg::ADDR_CONFIG, v);
  endtask : cfg

  task automatic settle();
    repeat (6) @(posedge clk);
  endtask : settle

  task automatic set_mode(input logic [2:0] m);
    @(posedge clk);
    mode_sel <= m;
    mode_valid <= 1'b1;
    @(posedge clk);
    mode_valid <= 1'b0;
  endtask : set_mode

  // Waits a bounded time for one of the pulse outputs to reach a level
  task automatic wait_for(input string what, input int k, input logic want);
    logic v;
    int n;
    n = 0;
    v = ~want;
    while (v !== want && n < 24) begin
      @(posedge clk);
      v = (k == 0) ? feed_decel : (k == 1) ? estop_mac : reset_mac;
      n++;
    end
    check(what, want, v);
  endtask : wait_for

  // ==========================================================
  // Main sequence
  initial begin
    logic [2:0] m;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    check("mode startup", esi_pkg::MODE_STARTUP, mode);
    bus(1'b0, esi_pkg::ADDR_CONFIG, 32'h0);
    check("config reset", esi_pkg::CFG_RESET, q);
    bus(1'b0, 4'h1, 32'h0);
    check("unmapped read", 32'h0, q);
    act(esi_pkg::ACT_PANEL_KEY);
    settle();
    check("mode edit", esi_pkg::MODE_EDIT, mode);
    set_mode(3'h2);
    aux_req <= 8'hff;
    settle();
    check("aux free", 8'hff, aux);
    press <= 1'b1;
    settle();
    check("mode estop", esi_pkg::MODE_ESTOP, mode);
    check("estop alarm", 1'b1, estop_alarm);
    check("feed stop", 1'b1, feed_stop);
    check("aux scope0", 8'hf8, aux);
    check("estop macro off", 1'b0, estop_mac);
    press <= 1'b0;
    settle();
    act(esi_pkg::ACT_RESET_KEY);
    settle();
    check("mode restored", esi_pkg::MODE_MANUAL, mode);
    check("alarm cleared", 1'b0, estop_alarm);
    cfg(32'h1 << esi_pkg::CFG_ESTOP_OUTPUT_SCOPE);
    press <= 1'b1;
    settle();
    check("aux scope1", 8'h00, aux);
    press <= 1'b0;
    settle();
    act(esi_pkg::ACT_RESET_KEY);
    cfg(32'h1 << esi_pkg::CFG_ESTOP_INPUT_DISABLE);
    press <= 1'b1;
    settle();
    check("stop ignored", esi_pkg::MODE_MANUAL, mode);
    check("no alarm", 1'b0, estop_alarm);
    press <= 1'b0;
    bus(1'b1, esi_pkg::ADDR_MACRO, 32'h3);
    cfg(32'h1 << esi_pkg::CFG_ESTOP_MACRO_ENABLE);
    press <= 1'b1;
    wait_for("estop macro run", 1, 1'b1);
    press <= 1'b0;
    macro_delay <= 4'h3;
    wait_for("estop macro end", 1, 1'b0);
    macro_delay <= 4'h0;
    act(esi_pkg::ACT_RESET_KEY);
    settle();
    for (int a = 0; a < 3; a++) begin
      m = 3'h1 << a;
      cfg(32'h1 << (esi_pkg::CFG_DRIVE_ALARM_LEVEL_Y + a));
      pins <= ~m;
      settle();
      // A level change can match the old pins briefly, so clear first
      act(esi_pkg::ACT_CLEAR_ALARM);
      settle();
      check("flag idle", 3'h0, dflag);
      pins <= 3'h7;
      settle();
      check("flag axis", m, dflag);
      check("manual feed stop", 1'b1, feed_stop);
      pins <= ~m;
      act(esi_pkg::ACT_CLEAR_ALARM);
      settle();
      check("flag cleared", 3'h0, dflag);
    end
    cfg(32'h1 << esi_pkg::CFG_DRIVE_ALARM_CHECK_DISABLE);
    pins <= 3'h0;
    settle();
    check("unchecked flag", 3'h0, dflag);
    check("unchecked feed", 1'b0, feed_stop);
    pins <= 3'h5;
    cfg(32'h0);
    set_mode(3'h3);
    settle();
    act(esi_pkg::ACT_CYCLE_START);
    settle();
    check("start blocked", 1'b0, program_run);
    check("flag x", 3'h2, dflag);
    pins <= 3'h7;
    settle();
    act(esi_pkg::ACT_CLEAR_ALARM);
    act(esi_pkg::ACT_CYCLE_START);
    settle();
    check("program run", 1'b1, program_run);
    act(esi_pkg::ACT_RESET_KEY);
    wait_for("decel", 0, 1'b1);
    check("spindle off", 1'b0, aux.spindle);
    check("coolant off", 1'b0, aux.coolant);
    settle();
    check("run ended", 1'b0, program_run);
    check("modal", 6'h05, modal);
    check("mode kept", esi_pkg::MODE_AUTO, mode);
    cfg(32'h1 << esi_pkg::CFG_RESET_SPINDLE_HOLD);
    act(esi_pkg::ACT_RESET_KEY);
    wait_for("decel hold", 0, 1'b1);
    check("spindle held", 1'b1, aux.spindle);
    set_mode(3'h2);
    cfg(32'h1 << esi_pkg::CFG_RESET_MACRO_ENABLE);
    act(esi_pkg::ACT_RESET_KEY);
    wait_for("reset macro run", 2, 1'b1);
    pins <= 3'h6;
    wait_for("reset macro abort", 2, 1'b0);
    pins <= 3'h7;
    settle();
    conclude();
  end
endmodule : esi_interlock_tb
